// ===== hdl/slcr_pkg.sv
// package: offsets, field positions, reset values and types of the link config bank
package slcr_pkg;
   // ==========================================
   // register offsets
   localparam logic [7:0] OFS_DRIVE = 8'h05;
   localparam logic [7:0] OFS_RSVD6 = 8'h06;
   localparam logic [7:0] OFS_RSVD7 = 8'h07;
   localparam logic [7:0] OFS_FAULT = 8'h08;
   localparam logic [7:0] OFS_RSVD12 = 8'h0C;
   localparam logic [7:0] OFS_REMAP = 8'h0D;
   localparam logic [7:0] OFS_ATTN = 8'h0E;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h11;
   localparam logic [7:0] OFS_PART = 8'h1E;
   localparam logic [7:0] OFS_CAPREV = 8'h1F;
   // ==========================================
   // reset values and special field codes
   localparam logic [7:0] RST_DRIVE = 8'h70;
   localparam logic [7:0] RST_RSVD6 = 8'h40;
   localparam logic [7:0] RST_RSVD7 = 8'h22;
   localparam logic [7:0] RST_RSVD12 = 8'h70;
   localparam logic [7:0] RST_REMAP = 8'h0F;
   localparam logic [7:0] RST_ATTN = 8'h00;
   localparam logic [1:0] FAULT_NORMAL = 2'h2;
   localparam logic [1:0] LEVEL_FORBIDDEN = 2'h0;
   localparam logic [3:0] SKEW_NONE = 4'hF;
   localparam logic [3:0] SKEW_FORBIDDEN = 4'h7;
   // ==========================================
   // field positions
   localparam int ATTN_BIT = 7;
   localparam int VFLIP_BIT = 6;
   localparam int HFLIP_BIT = 5;
   localparam int REMAP_BIT = 4;
   // interrupt status bits
   localparam int IRQ_FAULT = 0;
   localparam int IRQ_ATTN = 1;
   localparam int IRQ_W = 2;

   typedef struct packed {
      logic addr_send_select;
      logic filter_loop_bypass;
      logic [1:0] line_drive_level;
      logic [3:0] drive_emphasis;
   } slcr_drive_s;

   typedef struct packed {
      logic [1:0] neg_wire_fault;
      logic [1:0] pos_wire_fault;
   } slcr_fault_s;

   typedef enum logic [1:0] {
      ATTN_LOW = 2'b00,
      ATTN_HIGH = 2'b01
   } slcr_attn_e;
endpackage

// ===== hdl/slcr_regs.sv
// configuration and status register bank of the serial-link serializer
//
// Behaviour
// - address-send bit 0 sends address, 1 omits
// - drive level 01/10/11 give 200/300/400mV
// - negative wire fault status at bits 3:2
// - positive wire fault status at bits 1:0
// - attention bit falling drives line low
// - attention bit rising drives line high
// - bit 6 inverts vertical sync
// - bit 5 inverts horizontal sync
// - bit 4 routes aux control one to bit27
// - skew trim codes select +50..+400ps steps
// - skew code 1111 applies no skew
`timescale 1ns/1ps
module slcr_regs
   import slcr_pkg::*;
#(
   parameter logic [7:0] PART_CODE = 8'hA5,   // arbitrary value
   parameter logic [3:0] REVISION = 4'h1,
   parameter logic PROT_CAPABLE = 1'b1
) (
   // clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RST_B_I,
   // register port
   input wire logic [7:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [7:0] RDATA_O,
   // cable fault sense from the line monitor
   input wire slcr_fault_s FAULT_I,
   // video path
   input wire logic VSYNC_I,
   input wire logic HSYNC_I,
   input wire logic VIDEO_SPARE_BIT_I,
   input wire logic AUX_CONTROL_ONE_I,
   output logic VSYNC_O,
   output logic HSYNC_O,
   output logic INPUT_BIT_27_O,
   // analog controls
   output slcr_drive_s DRIVE_O,
   output logic [3:0] CLOCK_SKEW_TRIM_O,
   output logic SKEW_BYPASS_O,
   // remote attention and interrupt
   output logic REMOTE_ATTN_O,
   output logic IRQ_O
);
   // ==========================================
   // storage
   slcr_drive_s drive;
   logic [7:0] remap;
   logic [7:0] attn;
   slcr_fault_s fault;
   slcr_fault_s fault_prev;
   logic [IRQ_W-1:0] irq_stat;
   logic [IRQ_W-1:0] irq_mask;
   logic attn_prev;
   slcr_attn_e attn_state;
   logic [IRQ_W-1:0] irq_evt;
   logic [7:0] next_rdata;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   // ==========================================
   // writable registers
   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         drive <= RST_DRIVE;
      end else if (WR_I && hit(ADDR_I, OFS_DRIVE)) begin
         drive <= WDATA_I;
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         remap <= RST_REMAP;
      end else if (WR_I && hit(ADDR_I, OFS_REMAP)) begin
         // only bit 4 and the skew nibble exist; the rest reads as zero
         remap <= {3'h0, WDATA_I[4:0]};
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         attn <= RST_ATTN;
      end else if (WR_I && hit(ADDR_I, OFS_ATTN)) begin
         attn <= {WDATA_I[7:5], 5'h00};
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         irq_mask <= '0;
      end else if (WR_I && hit(ADDR_I, OFS_IRQ_MASK)) begin
         irq_mask <= WDATA_I[IRQ_W-1:0];
      end
   end

   // ==========================================
   // cable fault status, registered from the line monitor
   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         fault <= {FAULT_NORMAL, FAULT_NORMAL};
         fault_prev <= {FAULT_NORMAL, FAULT_NORMAL};
      end else begin
         fault <= FAULT_I;
         fault_prev <= fault;
      end
   end

   // ==========================================
   // remote attention line follows edges of the set bit, not its level
   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         attn_prev <= 1'b0;
         attn_state <= ATTN_LOW;
      end else begin
         attn_prev <= attn[ATTN_BIT];
         case (attn_state)
            ATTN_LOW: begin
               if (attn[ATTN_BIT] && !attn_prev) begin
                  attn_state <= ATTN_HIGH;
               end
            end
            ATTN_HIGH: begin
               if (!attn[ATTN_BIT] && attn_prev) begin
                  attn_state <= ATTN_LOW;
               end
            end
            default: begin
               attn_state <= ATTN_LOW;
            end
         endcase
      end
   end

   // ==========================================
   // interrupt status: an event in the clearing cycle wins
   always_comb begin
      irq_evt = '0;
      irq_evt[IRQ_FAULT] = fault != fault_prev;
      irq_evt[IRQ_ATTN] = attn[ATTN_BIT] != attn_prev;
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         irq_stat <= '0;
      end else if (WR_I && hit(ADDR_I, OFS_IRQ_STAT)) begin
         irq_stat <= (irq_stat & ~WDATA_I[IRQ_W-1:0]) | irq_evt;
      end else begin
         irq_stat <= irq_stat | irq_evt;
      end
   end

   // ==========================================
   // read path, data valid the cycle after the strobe
   always_comb begin
      next_rdata = 8'h00;
      case (ADDR_I)
         OFS_DRIVE: next_rdata = drive;
         OFS_RSVD6: next_rdata = RST_RSVD6;
         OFS_RSVD7: next_rdata = RST_RSVD7;
         OFS_FAULT: next_rdata = {4'h0, fault};
         OFS_RSVD12: next_rdata = RST_RSVD12;
         OFS_REMAP: next_rdata = remap;
         OFS_ATTN: next_rdata = attn;
         OFS_IRQ_STAT: next_rdata = {{(8-IRQ_W){1'b0}}, irq_stat};
         OFS_IRQ_MASK: next_rdata = {{(8-IRQ_W){1'b0}}, irq_mask};
         OFS_PART: next_rdata = PART_CODE;
         OFS_CAPREV: next_rdata = {3'h0, PROT_CAPABLE, REVISION};
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         RDATA_O <= 8'h00;
      end else if (RD_I) begin
         RDATA_O <= next_rdata;
      end else begin
         RDATA_O <= 8'h00;
      end
   end

   // ==========================================
   // outputs
   assign VSYNC_O = VSYNC_I ^ attn[VFLIP_BIT];
   assign HSYNC_O = HSYNC_I ^ attn[HFLIP_BIT];
   assign INPUT_BIT_27_O = remap[REMAP_BIT] ? AUX_CONTROL_ONE_I : VIDEO_SPARE_BIT_I;
   assign DRIVE_O = drive;
   // both halves of the code space map to the same steps, so pass the nibble on
   assign CLOCK_SKEW_TRIM_O = remap[3:0];
   assign SKEW_BYPASS_O = remap[3:0] == SKEW_NONE;
   assign REMOTE_ATTN_O = attn_state == ATTN_HIGH;
   assign IRQ_O = |(irq_stat & irq_mask);
endmodule

// ===== tb/slcr_regs_checker.sv
// port assertions for the link config bank
`timescale 1ns/1ps
module slcr_regs_checker
   import slcr_pkg::*;
(
   // clock, reset and register port
   input wire logic SYS_CLK_I,
   input wire logic RST_B_I,
   input wire logic WR_I,
   input wire logic RD_I,
   input wire logic [7:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic [7:0] RDATA_O,
   // status, video and analog controls
   input wire slcr_fault_s FAULT_I,
   input wire logic VSYNC_I,
   input wire logic HSYNC_I,
   input wire logic VIDEO_SPARE_BIT_I,
   input wire logic AUX_CONTROL_ONE_I,
   input wire logic VSYNC_O,
   input wire logic HSYNC_O,
   input wire logic INPUT_BIT_27_O,
   input wire logic SKEW_BYPASS_O,
   input wire logic REMOTE_ATTN_O,
   input wire slcr_drive_s DRIVE_O,
   input wire logic [3:0] CLOCK_SKEW_TRIM_O
);
   wire w_drv = WR_I && ADDR_I == OFS_DRIVE;
   wire w_att = WR_I && ADDR_I == OFS_ATTN;
   wire w_rmp = WR_I && ADDR_I == OFS_REMAP;
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_B_I);
   a_drive_write: assert property (w_drv |=> DRIVE_O == $past(WDATA_I))
      else $error("drive register not taken");
   a_fault_read: assert property (RD_I && ADDR_I == OFS_FAULT |=>
      RDATA_O == {4'h0, $past(FAULT_I, 2)}) else $error("fault readback wrong");
   a_attn_fall: assert property ($fell(REMOTE_ATTN_O) |->
      $past(w_att, 2) && !$past(WDATA_I[7], 2)) else $error("attention fell uncaused");
   a_attn_rise: assert property ($rose(REMOTE_ATTN_O) |->
      $past(w_att, 2) && $past(WDATA_I[7], 2)) else $error("attention rose uncaused");
   a_vsync_flip: assert property (w_att |=> VSYNC_O == (VSYNC_I ^ $past(WDATA_I[6])))
      else $error("vertical sync polarity wrong");
   a_hsync_flip: assert property (w_att |=> HSYNC_O == (HSYNC_I ^ $past(WDATA_I[5])))
      else $error("horizontal sync polarity wrong");
   a_bit27_route: assert property (w_rmp |=> INPUT_BIT_27_O ==
      ($past(WDATA_I[4]) ? AUX_CONTROL_ONE_I : VIDEO_SPARE_BIT_I)) else $error("bit 27 route");
   a_skew_write: assert property (w_rmp |=> CLOCK_SKEW_TRIM_O == $past(WDATA_I[3:0]))
      else $error("skew code not taken");
   a_skew_none: assert property (SKEW_BYPASS_O == (CLOCK_SKEW_TRIM_O == SKEW_NONE))
      else $error("skew bypass wrong");
   // read data must not linger past its one cycle
   a_rdata_idle: assert property (!RD_I |=> RDATA_O == 8'h00)
      else $error("read data outside its cycle");
endmodule
bind slcr_regs slcr_regs_checker chk_u (.SYS_CLK_I, .RST_B_I, .WR_I, .RD_I, .ADDR_I, .WDATA_I,
   .RDATA_O, .FAULT_I, .VSYNC_I, .HSYNC_I, .VIDEO_SPARE_BIT_I, .AUX_CONTROL_ONE_I, .VSYNC_O,
   .HSYNC_O, .INPUT_BIT_27_O, .SKEW_BYPASS_O, .REMOTE_ATTN_O, .DRIVE_O, .CLOCK_SKEW_TRIM_O);

// ===== tb/slcr_mcu_model.sv
// microcontroller model driving the register port
`timescale 1ns/1ps
module slcr_mcu_model (
   input wire logic clk_i,
   input wire logic [7:0] rdata_i,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o,
   output logic wr_o,
   output logic rd_o
);
   initial begin
      addr_o = 8'h00;
      wdata_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end
   // callers hand reserved places only their defaults and skip forbidden codes
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      #1 d = rdata_i;
   endtask
endmodule

// ===== tb/test_slcr_regs.sv
// self-checking bench of the link config bank
`timescale 1ns/1ps
module test_slcr_regs;
   import slcr_pkg::*;
   logic SYS_CLK_I, RST_B_I, WR_I, RD_I, VSYNC_I, HSYNC_I, VIDEO_SPARE_BIT_I, AUX_CONTROL_ONE_I;
   logic VSYNC_O, HSYNC_O, INPUT_BIT_27_O, SKEW_BYPASS_O, REMOTE_ATTN_O, IRQ_O;
   logic [7:0] ADDR_I, WDATA_I, RDATA_O, d;
   logic [3:0] CLOCK_SKEW_TRIM_O;
   slcr_fault_s FAULT_I;
   slcr_drive_s DRIVE_O;
   int mismatches = 0;
   int checked = 0;
   int cyc = 0;
   // rows: address, write data (00 means read only), expected read
   logic [23:0] rows[18] = '{24'h050070, 24'h060040, 24'h070022, 24'h08000A, 24'h0C0070,
      24'h0D000F, 24'h0E0000, 24'h110000, 24'h1E003C, 24'h1F0012, 24'h200000, 24'h055050,
      24'h05B3B3, 24'h064040, 24'h08050A, 24'h0D1F1F, 24'h0E6060, 24'h1E553C};
   // part code 3C is an arbitrary value
   slcr_regs #(.PART_CODE(8'h3C), .REVISION(4'h2), .PROT_CAPABLE(1'b1)) dut_u (
      .SYS_CLK_I, .RST_B_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O, .FAULT_I, .VSYNC_I,
      .HSYNC_I, .VIDEO_SPARE_BIT_I, .AUX_CONTROL_ONE_I, .VSYNC_O, .HSYNC_O, .INPUT_BIT_27_O,
      .DRIVE_O, .CLOCK_SKEW_TRIM_O, .SKEW_BYPASS_O, .REMOTE_ATTN_O, .IRQ_O);
   slcr_mcu_model mcu_u (.clk_i(SYS_CLK_I), .rdata_i(RDATA_O), .addr_o(ADDR_I),
      .wdata_o(WDATA_I), .wr_o(WR_I), .rd_o(RD_I));
   // ==========
   // checking and closing
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      checked++;
      if (s !== e) begin
         mismatches++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic wrap_up();
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      SYS_CLK_I = 1'b0;
      forever #10 SYS_CLK_I = ~SYS_CLK_I;
   end
   // the run needs well under a thousand cycles
   always @(posedge SYS_CLK_I) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         wrap_up();
      end
   end
   // ==========
   // stimulus
   initial begin
      RST_B_I = 1'b0;
      {VSYNC_I, HSYNC_I, VIDEO_SPARE_BIT_I, AUX_CONTROL_ONE_I} = 4'h1;
      FAULT_I = 4'hA;
      repeat (20) @(posedge SYS_CLK_I);
      RST_B_I <= 1'b1;
      repeat (2) @(posedge SYS_CLK_I);
      foreach (rows[i]) begin
         if (rows[i][15:8] != 8'h00) mcu_u.wr(rows[i][23:16], rows[i][15:8]);
         mcu_u.rd(rows[i][23:16], d);
         chk(d, rows[i][7:0]);
      end
      #1 chk({VSYNC_O, HSYNC_O}, 8'h03);
      // syncs must follow their inputs, not just the flip bits
      @(posedge SYS_CLK_I);
      {VSYNC_I, HSYNC_I} <= 2'b11;
      #1 chk({VSYNC_O, HSYNC_O}, 8'h00);
      $display("table done");
      for (int l = 1; l < 4; l++) begin
         mcu_u.wr(OFS_DRIVE, 8'(l * 16 + (l % 2) * 128));
         #1 chk(DRIVE_O, 8'(l * 16 + (l % 2) * 128));
      end
      for (int c = 0; c < 16; c++) if (c != 7) begin
         mcu_u.wr(OFS_REMAP, 8'(c));
         #1 chk({SKEW_BYPASS_O, CLOCK_SKEW_TRIM_O}, {c == 15, 4'(c)});
      end
      chk(INPUT_BIT_27_O, 8'h00);
      mcu_u.wr(OFS_REMAP, 8'h1F);
      #1 chk(INPUT_BIT_27_O, 8'h01);
      $display("codes done");
      mcu_u.wr(OFS_IRQ_MASK, 8'h03);
      mcu_u.wr(OFS_ATTN, 8'h80);
      repeat (2) @(posedge SYS_CLK_I);
      #1 chk({REMOTE_ATTN_O, IRQ_O, VSYNC_O}, 8'h07);
      mcu_u.rd(OFS_IRQ_STAT, d);
      chk(d, 8'h02);
      mcu_u.wr(OFS_IRQ_STAT, 8'h02);
      #1 chk(IRQ_O, 8'h00);
      @(posedge SYS_CLK_I);
      FAULT_I <= 4'h5;
      repeat (2) @(posedge SYS_CLK_I);
      #1 chk(IRQ_O, 8'h01);
      mcu_u.rd(OFS_FAULT, d);
      chk(d, 8'h05);
      mcu_u.wr(OFS_IRQ_MASK, 8'h00);
      mcu_u.wr(OFS_ATTN, 8'h00);
      repeat (2) @(posedge SYS_CLK_I);
      #1 chk({REMOTE_ATTN_O, IRQ_O}, 8'h00);
      $display("interrupt done");
      // leave non-default state behind so the reset checks can fail
      mcu_u.wr(OFS_REMAP, 8'h13);
      mcu_u.wr(OFS_ATTN, 8'h80);
      @(posedge SYS_CLK_I);
      RST_B_I <= 1'b0;
      @(posedge SYS_CLK_I);
      #1 chk(DRIVE_O, RST_DRIVE);
      chk({SKEW_BYPASS_O, CLOCK_SKEW_TRIM_O}, 8'h1F);
      chk(INPUT_BIT_27_O, 8'h00);
      chk({REMOTE_ATTN_O, IRQ_O}, 8'h00);
      @(posedge SYS_CLK_I);
      RST_B_I <= 1'b1;
      mcu_u.rd(OFS_REMAP, d);
      chk(d, RST_REMAP);
      mcu_u.rd(OFS_ATTN, d);
      chk(d, RST_ATTN);
      $display("reset done");
      wrap_up();
   end
endmodule
